// ==== eep_pkg.sv ====
// Constants and types shared by the two-wire serial byte memory target.
// Assumes a single 100 MHz system clock; the bus lines arrive asynchronously.
//
// Function
// - 2K: three select pins compared
// - 4K: upper two select pins compared
// - 8K: only upper select pin compared
// - 16K: no select pins compared
// - Data line driven open-drain only
// - Sample on clock rise, shift on fall
// - Protect low: normal reads and writes
// - Protect high: whole array write-locked
// - 2K: 32 pages of 8, 8-bit address
// - 4K: 32 pages of 16, 9-bit address
// - 8K: 64 pages of 16, 10-bit address
// - 16K: 128 pages of 16, 11-bit address
// - Data moves with clock low only
// - Data fall, clock high: start
// - Data rise, clock high: stop
// - Byte words, ninth-clock low acknowledge
// - Standby at power-up and after stop
// - Stop after read returns to standby
// - Page write up to 8 or 16
// - Partial page leaves other bytes intact
// - Self-timed write of at most 5 ms
// - Address word: 1010, three bits, read-high
// - Ack on match, silent when busy/mismatch
// - Page write wraps within the page
// - Counter is last address plus one

package eep_pkg;

   // System clock rate
   localparam int CLK_MHZ = 100;

   // Self-timed write cycle, 5 ms longest, rounded down to cycles
   localparam int TWR_US = 5000;
   localparam int TWR_CYC = TWR_US * CLK_MHZ;

   // Glitch filter window on the bus lines
   localparam int FILT_NS = 20;
   localparam int FILT_CYC = (FILT_NS * CLK_MHZ) / 1000;

   // Fixed pattern in the top nibble of the device address word
   localparam logic [3:0] DEV_CODE = 4'ha;

   // Widest word address, for the 16K variant
   localparam int ADDR_MAX_W = 11;
   localparam int ADDR_MIN_W = 8;

   // Bit counter values at the acknowledge slot and after it
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_MACK = 4'h9;

   // Idle level of both bus lines
   localparam logic LINE_IDLE = 1'b1;

   // Transfer states
   typedef enum logic [2:0] {
      EEP_IDLE = 3'b000,
      EEP_DEV = 3'b001,
      EEP_WORD = 3'b010,
      EEP_WDATA = 3'b011,
      EEP_RDATA = 3'b100,
      EEP_WAIT = 3'b101
   } eep_state_e;

endpackage

// ==== eep_buf2.sv ====
// Two-entry buffer with valid/ready on both sides.
// Assumes both sides run on the same clock as the buffer.
`timescale 1ns/100ps
`default_nettype none

module eep_buf2 #(
   parameter int W = 12
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [W-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [W-1:0] out_data_out
);

   logic [W-1:0] slot [0:1];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   logic push;
   logic pop;

   // Honest full and empty straight from the fill count
   assign in_ready_out = (count != 2'h2);
   assign out_valid_out = (count != 2'h0);
   assign out_data_out = slot[rd_ptr];
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;

   // Storage has no reset; only the count marks what is valid
   always_ff @(posedge clk_in) begin
      if (push) begin
         slot[wr_ptr] <= in_data_in;
      end
   end

   // Pointers and count
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         if (push && !pop) begin
            count <= count + 2'h1;
         end else if (pop && !push) begin
            count <= count - 2'h1;
         end
      end
   end

endmodule

`default_nettype wire

// ==== eep_target.sv ====
// Two-wire serial byte memory target: bus front end, transfer control,
// page latch, self-timed commit and the array itself.
// Assumes the serial clock, data, protect and select pins are asynchronous
// and that the bench resolves the open-drain data wire from sda_oe_out.
`timescale 1ns/100ps
`default_nettype none

module eep_target #(
   parameter int ADDR_W = 11,
   parameter int TWR_CYCLES = eep_pkg::TWR_CYC,
   parameter int FILT_CYC = eep_pkg::FILT_CYC
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic wp_in,
   input wire logic select_pin_upper_in,
   input wire logic select_pin_middle_in,
   input wire logic select_pin_lower_in,
   output logic standby_out,
   output logic write_busy_out
);

   // 2K has 8-byte pages, all larger sizes 16-byte pages
   localparam int PG_W = (ADDR_W == eep_pkg::ADDR_MIN_W) ? 3 : 4;
   localparam int NPG = 1 << PG_W;
   localparam int ROW_W = ADDR_W - PG_W;
   localparam int DEPTH = 1 << ADDR_W;
   localparam int TMR_W = $clog2(TWR_CYCLES + 1);
   localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(TWR_CYCLES - NPG - 1);

   ////////////////////////////////////////////////////////////////////////
   // Reset release

   logic [1:0] rst_sync;
   logic rst_n;

   // Assert at once, release two edges later
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and glitch filter

   logic [1:0] line_raw;
   logic [1:0] line_s1;
   logic [1:0] line_s2;
   logic [1:0] line_f;
   logic [1:0] line_prev;
   logic [3:0] misc_s1;
   logic [3:0] misc_s2;
   logic scl_f;
   logic sda_f;
   logic wp_s;
   logic [2:0] sel_s;

   assign line_raw = {scl_in, sda_in};

   // Each bus line passes two flops, then must hold for the window
   for (genvar g = 0; g < 2; g++) begin : g_line
      logic [2:0] stable_cnt;
      always_ff @(posedge clk_in or negedge rst_n) begin
         if (!rst_n) begin
            line_s1[g] <= eep_pkg::LINE_IDLE;
            line_s2[g] <= eep_pkg::LINE_IDLE;
            line_f[g] <= eep_pkg::LINE_IDLE;
            line_prev[g] <= eep_pkg::LINE_IDLE;
            stable_cnt <= 3'h0;
         end else begin
            line_s1[g] <= line_raw[g];
            line_s2[g] <= line_s1[g];
            line_prev[g] <= line_f[g];
            if (line_s2[g] != line_f[g]) begin
               if (stable_cnt == 3'(FILT_CYC - 1)) begin
                  line_f[g] <= line_s2[g];
                  stable_cnt <= 3'h0;
               end else begin
                  stable_cnt <= stable_cnt + 3'h1;
               end
            end else begin
               stable_cnt <= 3'h0;
            end
         end
      end
   end

   // Protect and select straps are slow levels, two flops suffice
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         misc_s1 <= 4'h0;
         misc_s2 <= 4'h0;
      end else begin
         misc_s1 <= {wp_in, select_pin_upper_in, select_pin_middle_in, select_pin_lower_in};
         misc_s2 <= misc_s1;
      end
   end

   assign scl_f = line_f[1];
   assign sda_f = line_f[0];
   assign wp_s = misc_s2[3];
   assign sel_s = misc_s2[2:0];

   ////////////////////////////////////////////////////////////////////////
   // Bus events

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   // Edges of the serial clock seen by the system clock
   assign scl_rise = scl_f && !line_prev[1];
   assign scl_fall = !scl_f && line_prev[1];
   // Data moving while the clock stays high frames a transfer
   assign start_det = scl_f && line_prev[1] && line_prev[0] && !sda_f;
   assign stop_det = scl_f && line_prev[1] && !line_prev[0] && sda_f;

   ////////////////////////////////////////////////////////////////////////
   // Address helpers

   // Page bits from the device word sit above the byte address
   function automatic logic [ADDR_W-1:0] word_addr(input logic [2:0] hi, input logic [7:0] lo);
      logic [eep_pkg::ADDR_MAX_W-1:0] full;
      full = {hi, lo};
      return full[ADDR_W-1:0];
   endfunction

   // Only the address bits that are not page bits face the pins
   function automatic logic sel_match(input logic [2:0] hi, input logic [2:0] pins);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 3; i++) begin
         if (i >= ADDR_W - eep_pkg::ADDR_MIN_W && hi[i] != pins[i]) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Transfer control

   eep_pkg::eep_state_e state;
   logic [3:0] bit_cnt;
   logic [7:0] rx;
   logic [7:0] tx;
   logic [2:0] dev_hi;
   logic [ADDR_W-1:0] addr;
   logic oe;
   logic wrote_any;
   logic push_valid;
   logic push_ready;
   logic [PG_W+7:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [PG_W+7:0] pop_data;
   logic dev_ok;
   logic word_ack;
   logic busy;
   logic commit;
   logic [7:0] mem [0:DEPTH-1];

   assign dev_ok = (rx[7:4] == eep_pkg::DEV_CODE) && sel_match(rx[3:1], sel_s) && !busy;
   assign word_ack = (state == eep_pkg::EEP_WORD) && scl_fall && (bit_cnt == eep_pkg::BIT_ACK);

   // Bit slots counted on clock rises; the bus drive changes on falls
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         state <= eep_pkg::EEP_IDLE;
         bit_cnt <= 4'h0;
         rx <= 8'h00;
         tx <= 8'h00;
         dev_hi <= 3'h0;
         addr <= '0;
         oe <= 1'b0;
         wrote_any <= 1'b0;
         push_valid <= 1'b0;
         push_data <= '0;
      end else begin
         push_valid <= 1'b0;
         if (start_det) begin
            state <= eep_pkg::EEP_DEV;
            bit_cnt <= 4'h0;
            oe <= 1'b0;
            wrote_any <= 1'b0;
         end else if (stop_det) begin
            state <= eep_pkg::EEP_IDLE;
            bit_cnt <= 4'h0;
            oe <= 1'b0;
         end else if (state != eep_pkg::EEP_IDLE && scl_rise) begin
            if (bit_cnt < eep_pkg::BIT_ACK) begin
               rx <= {rx[6:0], sda_f};
               bit_cnt <= bit_cnt + 4'h1;
            end else if (bit_cnt == eep_pkg::BIT_ACK) begin
               bit_cnt <= eep_pkg::BIT_MACK;
               if (state == eep_pkg::EEP_RDATA) begin
                  // Own ack slot fetches; controller leaving data high ends the read
                  if (sda_f && !oe) begin
                     state <= eep_pkg::EEP_WAIT;
                  end else begin
                     tx <= mem[addr];
                     addr <= addr + ADDR_W'(1);
                  end
               end
            end
         end else if (state != eep_pkg::EEP_IDLE && scl_fall) begin
            if (bit_cnt == eep_pkg::BIT_ACK) begin
               unique case (state)
                  eep_pkg::EEP_DEV: begin
                     if (dev_ok) begin
                        oe <= 1'b1;
                        dev_hi <= rx[3:1];
                        if (rx[0]) begin
                           // First byte is fetched at the rise of this ack slot
                           state <= eep_pkg::EEP_RDATA;
                        end else begin
                           state <= eep_pkg::EEP_WORD;
                        end
                     end else begin
                        state <= eep_pkg::EEP_IDLE;
                     end
                  end
                  eep_pkg::EEP_WORD: begin
                     oe <= 1'b1;
                     addr <= word_addr(dev_hi, rx);
                     state <= eep_pkg::EEP_WDATA;
                  end
                  eep_pkg::EEP_WDATA: begin
                     // A full buffer refuses the byte rather than lose it
                     if (push_ready) begin
                        oe <= 1'b1;
                        push_valid <= 1'b1;
                        push_data <= {addr[PG_W-1:0], rx};
                        addr <= {addr[ADDR_W-1:PG_W], addr[PG_W-1:0] + PG_W'(1)};
                        wrote_any <= 1'b1;
                     end else begin
                        state <= eep_pkg::EEP_WAIT;
                     end
                  end
                  default: begin
                     oe <= 1'b0;
                  end
               endcase
            end else if (bit_cnt == eep_pkg::BIT_MACK) begin
               bit_cnt <= 4'h0;
               oe <= (state == eep_pkg::EEP_RDATA) && !tx[7];
               tx <= {tx[6:0], 1'b0};
            end else if (state == eep_pkg::EEP_RDATA && bit_cnt != 4'h0) begin
               oe <= !tx[7];
               tx <= {tx[6:0], 1'b0};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Byte buffer between the bus side and the page latch

   // Draining stalls while the page latch is being committed
   assign pop_ready = !commit;

   eep_buf2 #(
      .W(PG_W + 8)
   ) u_buf (
      .clk_in(clk_in),
      .rst_n_in(rst_n),
      .in_valid_in(push_valid),
      .in_ready_out(push_ready),
      .in_data_in(push_data),
      .out_valid_out(pop_valid),
      .out_ready_in(pop_ready),
      .out_data_out(pop_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Page latch

   logic [7:0] page_data [0:NPG-1];
   logic [NPG-1:0] page_mask;
   logic [ROW_W-1:0] page_row;
   logic [ADDR_W-1:0] word_next;

   assign word_next = word_addr(dev_hi, rx);

   // The mask marks which bytes this transfer really wrote
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         page_mask <= '0;
         page_row <= '0;
      end else if (word_ack) begin
         page_mask <= '0;
         page_row <= word_next[ADDR_W-1:PG_W];
      end else if (pop_valid && pop_ready) begin
         page_mask[pop_data[PG_W+7:8]] <= 1'b1;
      end
   end

   // Later bytes to the same offset overwrite earlier ones
   always_ff @(posedge clk_in) begin
      if (pop_valid && pop_ready) begin
         page_data[pop_data[PG_W+7:8]] <= pop_data[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Self-timed write cycle

   logic [TMR_W-1:0] timer;
   logic [PG_W-1:0] cidx;

   // Timer covers the wait, the copy fits inside the same budget
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
         commit <= 1'b0;
         timer <= '0;
         cidx <= '0;
      end else if (!busy) begin
         // A protected device drops the latched page
         if (stop_det && state == eep_pkg::EEP_WDATA && wrote_any && !wp_s) begin
            busy <= 1'b1;
            timer <= TMR_LOAD;
         end
      end else if (!commit) begin
         if (timer == '0) begin
            commit <= 1'b1;
            cidx <= '0;
         end else begin
            timer <= timer - TMR_W'(1);
         end
      end else begin
         cidx <= cidx + PG_W'(1);
         if (cidx == PG_W'(NPG - 1)) begin
            commit <= 1'b0;
            busy <= 1'b0;
         end
      end
   end

   // Only marked bytes reach the array; the rest of the page stays
   always_ff @(posedge clk_in) begin
      if (commit && page_mask[cidx]) begin
         mem[{page_row, cidx}] <= page_data[cidx];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   // Open drain: the pad only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe_out = oe;
   assign standby_out = (state == eep_pkg::EEP_IDLE) && !busy;
   assign write_busy_out = busy;

endmodule

`default_nettype wire

// ==== eep_ctl.sv ====
// Bus controller model: makes the serial clock and pulls the data wire.
// Assumes the bench resolves the wire from both pull-down enables.
`timescale 1ns/100ps
`default_nettype none

module eep_ctl (
   input wire logic clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_oe_out
);
   // Bus idle at time zero
   initial begin
      scl_out = 1'b1;
      sda_oe_out = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Quarter of the 80 ns bus period
   task automatic qtr(input int n);
      repeat (2 * n) @(posedge clk_in);
   endtask

   // Long low phase: the target's filter and drive lag must settle
   // before the clock rises, or its own data move looks like a start
   task automatic bit_io(input logic b, output logic r);
      sda_oe_out <= !b;
      repeat (4) @(posedge clk_in);
      scl_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      r = sda_in;
      scl_out <= 1'b0;
      qtr(1);
   endtask

   // Long release first so a lingering acknowledge cannot fake a stop
   task automatic start_c;
      sda_oe_out <= 1'b0;
      qtr(3);
      scl_out <= 1'b1;
      qtr(2);
      sda_oe_out <= 1'b1;
      qtr(2);
      scl_out <= 1'b0;
      qtr(1);
   endtask

   task automatic stop_c;
      sda_oe_out <= 1'b1;
      qtr(1);
      scl_out <= 1'b1;
      qtr(2);
      sda_oe_out <= 1'b0;
      qtr(2);
   endtask

   // Eight bits most significant first, then the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                       output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(ack_in, ack);
   endtask

   // Nine released clocks, then a stop leaves the bus idle
   task automatic recover;
      logic r;
      for (int i = 0; i < 9; i++) begin
         bit_io(1'b1, r);
      end
      stop_c;
   endtask
endmodule
`default_nettype wire

// ==== eep_target_props.sv ====
// Checker for the serial byte memory target, bound to its top module.
// Assumes one clock domain and the pin-level reset.
`timescale 1ns/100ps
`default_nettype none

module eep_target_props #(
   parameter int TWR_CYCLES = 500000
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   input wire logic wp_in,
   input wire logic standby_out,
   input wire logic write_busy_out
);
   default clocking dck @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   int busy_cnt;

   // Length of the running write cycle
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         busy_cnt <= 0;
      end else if (write_busy_out) begin
         busy_cnt <= busy_cnt + 1;
      end else begin
         busy_cnt <= 0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Line conditions at the pins
   sequence stop_s;
      scl_in && $past(scl_in) && sda_in && !$past(sda_in);
   endsequence
   sequence start_s;
      scl_in && $past(scl_in) && !sda_in && $past(sda_in);
   endsequence

   od_value_a: assert property (sda_out == 1'b0)
      else $error("data output value not low");
   busy_wake_a: assert property (write_busy_out |-> !standby_out)
      else $error("standby during write cycle");
   busy_silent_a: assert property (write_busy_out |-> !sda_oe_out)
      else $error("target drove data while busy");
   busy_len_a: assert property ($fell(write_busy_out) |->
      busy_cnt >= TWR_CYCLES - 2 && busy_cnt <= TWR_CYCLES + 1)
      else $error("write cycle length wrong");
   busy_bus_idle_a: assert property ($rose(write_busy_out) |-> scl_in && sda_in)
      else $error("write cycle began with bus active");
   wp_lock_a: assert property ($rose(write_busy_out) |-> !wp_in && !$past(wp_in, 8))
      else $error("write cycle while protected");
   stop_rest_a: assert property (stop_s |-> ##[1:12] (standby_out || write_busy_out))
      else $error("no standby after stop");
   idle_quiet_a: assert property (standby_out |-> !sda_oe_out)
      else $error("data driven in standby");
   start_wake_a: assert property (start_s ##0 !write_busy_out |-> ##[1:12] !standby_out)
      else $error("start not taken");
endmodule

bind eep_target eep_target_props #(.TWR_CYCLES(TWR_CYCLES)) i_eep_target_props (
   .clk_in(clk_in), .rstn_in(rstn_in), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe_out(sda_oe_out), .wp_in(wp_in),
   .standby_out(standby_out), .write_busy_out(write_busy_out));
`default_nettype wire

// ==== eep_target_bench.sv ====
// Self-checking bench for the serial byte memory target, 2K build.
// Assumes the controller model and the checker are compiled beside it.
`timescale 1ns/100ps
`default_nettype none

module eep_target_bench;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic wp_in = 1'b0;
   logic [2:0] sel = 3'h0;
   logic scl, ctl_oe, dev_oe, dev_sda, standby, busy, sda;
   logic [7:0] mem [256];
   logic [7:0] pg;
   int mismatches = 0;
   int cmp_count = 0;

   // Open-drain wire with pull-up
   assign sda = !(dev_oe || ctl_oe);
   always #5 clk_in = ~clk_in;

   eep_target #(.ADDR_W(8), .TWR_CYCLES(300), .FILT_CYC(2)) i_eep_target (
      .clk_in(clk_in), .rstn_in(rstn_in), .scl_in(scl), .sda_in(sda),
      .sda_out(dev_sda), .sda_oe_out(dev_oe), .wp_in(wp_in),
      .select_pin_upper_in(sel[2]), .select_pin_middle_in(sel[1]),
      .select_pin_lower_in(sel[0]), .standby_out(standby), .write_busy_out(busy));
   eep_ctl i_eep_ctl (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_oe_out(ctl_oe));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] dev_word(input logic [2:0] s, input logic rd);
      return {eep_pkg::DEV_CODE, s, rd};
   endfunction
   // Page write address stays within its 8-byte page
   function automatic logic [7:0] in_page(input logic [7:0] a, input int i);
      return {a[7:3], a[2:0] + 3'(i)};
   endfunction

   task automatic conclude;
      if (mismatches == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Bounded wait for standby
   task automatic wait_idle;
      int n;
      n = 0;
      while (standby !== 1'b1 && n < 2000) begin
         @(posedge clk_in);
         n++;
      end
      if (n == 2000) begin
         mismatches++;
         conclude;
      end
   endtask

   task automatic send(input logic [7:0] d, input logic exp_ack);
      logic [7:0] q;
      logic ack;
      i_eep_ctl.xfer(d, 1'b1, q, ack);
      check({7'h0, ack}, {7'h0, exp_ack});
   endtask

   // Write n random bytes; a device word during the cycle must go unanswered
   task automatic wr(input logic [7:0] a, input int n, input logic wp);
      logic [7:0] d;
      @(posedge clk_in);
      wp_in <= wp;
      i_eep_ctl.start_c;
      send(dev_word(sel, 1'b0), 1'b0);
      send(a, 1'b0);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         send(d, 1'b0);
         if (!wp) begin
            mem[in_page(a, i)] = d;
         end
      end
      i_eep_ctl.stop_c;
      repeat (12) @(posedge clk_in);
      check({7'h0, busy}, {7'h0, !wp});
      if (!wp) begin
         i_eep_ctl.start_c;
         send(dev_word(sel, 1'b0), 1'b1);
         i_eep_ctl.stop_c;
      end
      wait_idle;
      @(posedge clk_in);
      wp_in <= 1'b0;
   endtask

   // Sequential read of n bytes, optionally after a dummy address write
   task automatic rd(input logic [7:0] a, input int n, input logic set_addr);
      logic [7:0] q;
      logic ack;
      i_eep_ctl.start_c;
      if (set_addr) begin
         send(dev_word(sel, 1'b0), 1'b0);
         send(a, 1'b0);
         i_eep_ctl.start_c;
      end
      send(dev_word(sel, 1'b1), 1'b0);
      for (int i = 0; i < n; i++) begin
         i_eep_ctl.xfer(8'hff, i == n - 1, q, ack);
         check(q, mem[8'(a + i)]);
      end
      i_eep_ctl.stop_c;
      wait_idle;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(32'he9d5));
      repeat (16) @(posedge clk_in);
      rstn_in <= 1'b1;
      sel <= 3'($urandom);
      repeat (20) @(posedge clk_in);
      i_eep_ctl.recover;
      wait_idle;
      wr(8'hf8, 8, 1'b0);
      wr(8'h00, 8, 1'b0);
      pg = {5'($urandom), 3'h0};
      wr(pg, 8, 1'b0);
      wr(pg + 8'h06, 3, 1'b0);
      rd(pg + 8'h01, 1, 1'b0);
      rd(8'hfc, 8, 1'b1);
      wr(pg + 8'h02, 2, 1'b1);
      rd(pg, 8, 1'b1);
      // Every select value, then a wrong fixed code
      for (int s = 0; s < 9; s++) begin
         i_eep_ctl.start_c;
         send(s < 8 ? dev_word(3'(s), 1'b0) : {4'hb, sel, 1'b0}, s == 8 || 3'(s) != sel);
         i_eep_ctl.stop_c;
         wait_idle;
      end
      conclude;
   end
endmodule
`default_nettype wire
